// *** verilog/rcp_pkg.sv ***
// Purpose: Constants for the serial command interpreter of the tag reader.
// Assumes: 10 MHz clock, bytes arrive from a same-clock receiver.
// Notes: Register offsets are APB byte addresses.
// Summary of operation
// - LED override set stops automatic indicator driving; host commands control it.
// - LED g: green on red off, DG; r: red on, DR; n: both off, DN.
// - Settings command takes type and value; applies temporarily, stored copy untouched.
// - Settings byte: gain upper bits, sampling lower; 0x80 is gain 2, sampling 0.
// - Settings command answers D then the received type character.
// - Station-ID query returns the ID, delayed into a slot chosen by the ID.
// - Up to 253 slots, each 6 times 10 bit periods long.
// - Station ID only matters in binary mode; its reply uses version 1 framing.
// - Page lock takes a page byte, only two families; answers k plus page.
// - Lock failure answers C, F, N, O or R.
// - Login takes four password bytes; answers L, X wrong key, N no tag.
// - Select type restricts to one type, answers o plus type, not saved.
// - Type codes are case-sensitive; A is all, h and H differ.
// - Include type adds a type, answers o+ plus type.
// - Exclude type removes a type, answers o- plus type.
// - Noisy flag: only period cancels continuous read, other characters ignored.
package rcp_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_IRQ  = 8'h08;
	localparam logic [7:0] OFF_MASK = 8'h0c;
	localparam logic [7:0] OFF_SET  = 8'h10;
	localparam int CTL_LED = 0;
	localparam int CTL_BIN = 1;
	localparam int CTL_NOISY = 2;
	localparam int CTL_ID_LO = 8;
	localparam int CTL_DIV_LO = 16;
	localparam logic [15:0] DIV_RESET = 16'h0411;
	localparam logic [7:0] ID_RESET = 8'h00;
	localparam logic [7:0] SLOT_MAX = 8'hfd;
	localparam int SLOT_BITS = 10;
	localparam int SLOT_CHARS = 6;
	localparam int NTYPE = 7;
	localparam logic [6:0] TYPES_ALL = 7'h7f;
	localparam logic [7:0] SET_RESET = 8'h84;
	localparam int GAIN_HI = 7;
	localparam int GAIN_LO = 6;
	localparam int SAMP_HI = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_BAD = 1;
	localparam int IRQ_STOP = 2;
	localparam logic [7:0] CH_D = 8'h44, CH_G = 8'h47, CH_R = 8'h52, CH_N = 8'h4e;
	localparam logic [7:0] CH_LG = 8'h67, CH_LR = 8'h72, CH_LN = 8'h6e;
	localparam logic [7:0] CH_LD = 8'h64, CH_LK = 8'h6b, CH_LL = 8'h6c, CH_LO = 8'h6f;
	localparam logic [7:0] CH_PLUS = 8'h2b, CH_MINUS = 8'h2d, CH_DOT = 8'h2e;
	localparam logic [7:0] CH_A = 8'h41, CH_U = 8'h55, CH_Z = 8'h5a, CH_T = 8'h54;
	localparam logic [7:0] CH_LH = 8'h68, CH_H = 8'h48, CH_Q = 8'h51;
	localparam logic [7:0] CH_C = 8'h43, CH_F = 8'h46, CH_O = 8'h4f, CH_X = 8'h58;
	localparam logic [7:0] CH_L = 8'h4c, CH_S = 8'h53, CH_QM = 8'h3f;
	localparam logic [2:0] TS_OK = 3'h0, TS_CRC = 3'h1, TS_FAIL = 3'h2, TS_NOTAG = 3'h3;
	localparam logic [2:0] TS_MODE = 3'h4, TS_RANGE = 3'h5, TS_KEY = 3'h6;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ARG  = 3'b001,
		ST_EXEC = 3'b010,
		ST_TAG  = 3'b011,
		ST_SLOT = 3'b100,
		ST_SEND = 3'b101
	} rcp_state_e;
endpackage : rcp_pkg

// *** verilog/rcp_parser.sv ***
// Purpose: Command interpreter: LED, tag settings, station ID, lock, login, type set.
// Assumes: Byte link and tag engine on clk; one command in flight at a time.
// Notes: Bytes arriving while a command runs are dropped.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module rcp_parser
	import rcp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxValid,
	input  wire logic [7:0]  rxData,
	output logic             txValid,
	output logic [7:0]       txData,
	input  wire logic        txReady,
	output logic             txFrameV1,
	input  wire logic        tagActivity,
	input  wire logic        contActive,
	output logic             contStop,
	output logic             tagReq,
	output logic             tagLock,
	output logic [31:0]      tagArg,
	input  wire logic        tagDone,
	input  wire logic [2:0]  tagStatus,
	input  wire logic [7:0]  tagPresent,
	output logic             ledGreen,
	output logic             ledRed,
	output logic [6:0]       typeMask,
	output logic [1:0]       curGain,
	output logic [3:0]       curSample,
	output logic             irq
);
	function automatic logic [3:0] typeIndex(input logic [7:0] c);
		case (c)
			CH_U:    typeIndex = 4'h8;
			CH_Z:    typeIndex = 4'h9;
			CH_T:    typeIndex = 4'ha;
			CH_LH:   typeIndex = 4'hb;
			CH_H:    typeIndex = 4'hc;
			CH_Q:    typeIndex = 4'hd;
			CH_R:    typeIndex = 4'he;
			default: typeIndex = 4'h0;
		endcase
	endfunction : typeIndex

	rcp_state_e  state;
	logic [31:0] ctrl;
	logic [2:0]  irqStat;
	logic [2:0]  irqMask;
	logic [7:0]  cmd;
	logic [2:0]  need;
	logic [2:0]  argCnt;
	logic [7:0]  args [0:3];
	logic [7:0]  reply [0:3];
	logic [2:0]  replyLen;
	logic [2:0]  sendIdx;
	logic [7:0]  settings [0:NTYPE-1];
	logic [2:0]  typeSel;
	logic [7:0]  slotLeft;
	logic [23:0] cycLeft;
	logic        idReply;
	logic        evBad;
	logic        evStop;

	wire         ledOverride = ctrl[CTL_LED];
	wire         binMode = ctrl[CTL_BIN];
	wire         noisy = ctrl[CTL_NOISY];
	wire [7:0]   stationId = ctrl[CTL_ID_LO +: 8];
	wire [15:0]  baudDiv = ctrl[CTL_DIV_LO +: 16];
	wire [23:0]  slotCycles = baudDiv * 8'(SLOT_BITS * SLOT_CHARS);
	wire [7:0]   slotCount = (stationId > SLOT_MAX) ? SLOT_MAX : stationId;
	wire         apbSetup = psel && !penable;
	wire         apbAcc = psel && penable;
	wire         mapped = paddr == OFF_CTRL || paddr == OFF_STAT || paddr == OFF_IRQ
		|| paddr == OFF_MASK || paddr == OFF_SET;
	wire         irqRead = apbAcc && !pwrite && paddr == OFF_IRQ;
	wire         rxIdle = rxValid && state == ST_IDLE;
	wire         stopChar = !noisy || rxData == CH_DOT;
	wire [3:0]   ti0 = typeIndex(args[0]);
	wire [3:0]   ti1 = typeIndex(args[1]);
	wire         isLed = args[0] == CH_LG || args[0] == CH_LR || args[0] == CH_LN;
	wire         isSub = args[0] == CH_PLUS || args[0] == CH_MINUS;
	wire         lockOk = tagPresent == CH_Q || tagPresent == CH_R || tagPresent == 8'h00;
	wire         execD = state == ST_EXEC && cmd == CH_LD;
	wire         execO = state == ST_EXEC && cmd == CH_LO;
	wire         txFire = txValid && txReady;
	wire         lastByte = txFire && sendIdx == replyLen - 3'd1;
	// Events of this cycle join the status read, so a read-clear cannot swallow them
	wire [2:0]   irqEvents = {evStop, evBad, lastByte};

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (rxValid && contActive) begin
						if (stopChar) state <= ST_SEND;
					end else if (rxValid) begin
						if (rxData == CH_LG) state <= binMode ? ST_SLOT : ST_SEND;
						else if (rxData == CH_LD || rxData == CH_LK || rxData == CH_LL
							|| rxData == CH_LO) state <= ST_ARG;
						else state <= ST_SEND;
					end
				end
				ST_ARG: begin
					if (rxValid && argCnt + 3'd1 == need) state <= ST_EXEC;
				end
				ST_EXEC: begin
					if ((cmd == CH_LD && need == 3'd1 && !isLed && ti0[3])
						|| (cmd == CH_LO && need == 3'd1 && isSub)) state <= ST_ARG;
					else if ((cmd == CH_LK && lockOk) || cmd == CH_LL) state <= ST_TAG;
					else state <= ST_SEND;
				end
				ST_TAG: if (tagDone) state <= ST_SEND;
				ST_SLOT: if (slotLeft == 8'h00 && cycLeft == 24'h0) state <= ST_SEND;
				ST_SEND: if (lastByte) state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cmd <= 8'h00;
			need <= 3'd0;
			argCnt <= 3'd0;
		end else if (rxIdle) begin
			cmd <= rxData;
			need <= (rxData == CH_LL) ? 3'd4 : 3'd1;
			argCnt <= 3'd0;
		end else if (state == ST_ARG && rxValid) begin
			args[argCnt[1:0]] <= rxData;
			argCnt <= argCnt + 3'd1;
		end else if (state == ST_EXEC && need == 3'd1 && ((cmd == CH_LD && !isLed && ti0[3])
			|| (cmd == CH_LO && isSub))) begin
			need <= 3'd2;
		end
	end

	// Slot countdown runs only in binary mode; ASCII mode answers at once
	always_ff @(posedge clk) begin
		if (rst) begin
			slotLeft <= 8'h00;
			cycLeft <= 24'h0;
		end else if (rxIdle && !contActive && rxData == CH_LG) begin
			slotLeft <= slotCount;
			cycLeft <= 24'h0;
		end else if (state == ST_SLOT && cycLeft != 24'h0) begin
			cycLeft <= cycLeft - 24'h1;
		end else if (state == ST_SLOT && slotLeft != 8'h00) begin
			slotLeft <= slotLeft - 8'h01;
			cycLeft <= slotCycles - 24'h1;
		end
	end

	// Reply builder: every path into sending loads exactly one answer
	always_ff @(posedge clk) begin
		if (rst) begin
			replyLen <= 3'd0;
			idReply <= 1'b0;
			evBad <= 1'b0;
			evStop <= 1'b0;
		end else begin
			evBad <= 1'b0;
			evStop <= 1'b0;
			if (rxIdle && contActive) begin
				if (stopChar) begin
					reply[0] <= CH_S;
					replyLen <= 3'd1;
					evStop <= 1'b1;
				end
			end else if (rxIdle) begin
				idReply <= rxData == CH_LG;
				reply[0] <= (rxData == CH_LG) ? stationId : CH_QM;
				replyLen <= 3'd1;
				evBad <= rxData != CH_LG && rxData != CH_LD && rxData != CH_LK
					&& rxData != CH_LL && rxData != CH_LO;
			end else if (execD && (need == 3'd2 || isLed)) begin
				reply[0] <= CH_D;
				reply[1] <= isLed ? args[0] - 8'h20 : args[0];
				replyLen <= 3'd2;
			// First pass of a settings command only collects the type; not a refusal
			end else if ((execD && !ti0[3]) || (execO && !isSub && !ti0[3] && args[0] != CH_A)
				|| (execO && need == 3'd2 && !ti1[3] && args[1] != CH_A)) begin
				reply[0] <= CH_QM;
				replyLen <= 3'd1;
				evBad <= 1'b1;
			end else if (execO && !isSub) begin
				reply[0] <= CH_LO;
				reply[1] <= args[0];
				replyLen <= 3'd2;
			end else if (execO && need == 3'd2) begin
				reply[0] <= CH_LO;
				reply[1] <= args[0];
				reply[2] <= args[1];
				replyLen <= 3'd3;
			end else if (state == ST_EXEC && cmd == CH_LK && !lockOk) begin
				reply[0] <= CH_O;
				replyLen <= 3'd1;
			end else if (state == ST_TAG && tagDone) begin
				replyLen <= 3'd1;
				case (tagStatus)
					TS_OK: begin
						reply[0] <= tagLock ? CH_LK : CH_L;
						reply[1] <= args[0];
						replyLen <= tagLock ? 3'd2 : 3'd1;
					end
					TS_CRC:   reply[0] <= CH_C;
					TS_FAIL:  reply[0] <= CH_F;
					TS_NOTAG: reply[0] <= CH_N;
					TS_MODE:  reply[0] <= CH_O;
					TS_RANGE: reply[0] <= CH_R;
					TS_KEY:   reply[0] <= CH_X;
					default:  reply[0] <= CH_F;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			txValid <= 1'b0;
			txData <= 8'h00;
			sendIdx <= 3'd0;
			txFrameV1 <= 1'b0;
		end else if (state == ST_SEND && !txValid) begin
			txValid <= 1'b1;
			txData <= reply[sendIdx[1:0]];
			txFrameV1 <= idReply && binMode;
		end else if (txFire) begin
			txValid <= 1'b0;
			sendIdx <= lastByte ? 3'd0 : sendIdx + 3'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tagReq <= 1'b0;
			tagLock <= 1'b0;
			tagArg <= 32'h0;
		end else begin
			tagReq <= state == ST_EXEC && ((cmd == CH_LK && lockOk) || cmd == CH_LL);
			if (state == ST_EXEC) begin
				tagLock <= cmd == CH_LK;
				tagArg <= {args[0], args[1], args[2], args[3]};
			end
		end
	end

	// Temporary settings only; the stored copy lives outside this block
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < NTYPE; i++) settings[i] <= SET_RESET;
			typeSel <= 3'd0;
			typeMask <= TYPES_ALL;
			curGain <= SET_RESET[GAIN_HI:GAIN_LO];
			curSample <= SET_RESET[SAMP_HI:0];
		end else begin
			if (execD && need == 3'd2) begin
				settings[ti0[2:0]] <= args[1];
				if (ti0[2:0] == typeSel) begin
					curGain <= args[1][GAIN_HI:GAIN_LO];
					curSample <= args[1][SAMP_HI:0];
				end
			end
			if (execO && !isSub && args[0] == CH_A) begin
				typeMask <= TYPES_ALL;
			end else if (execO && !isSub && ti0[3]) begin
				typeMask <= 7'(1) << ti0[2:0];
				typeSel <= ti0[2:0];
				curGain <= settings[ti0[2:0]][GAIN_HI:GAIN_LO];
				curSample <= settings[ti0[2:0]][SAMP_HI:0];
			end else if (execO && need == 3'd2 && args[1] == CH_A) begin
				typeMask <= (args[0] == CH_PLUS) ? TYPES_ALL : 7'h00;
			end else if (execO && need == 3'd2 && ti1[3]) begin
				if (args[0] == CH_PLUS) typeMask <= typeMask | (7'(1) << ti1[2:0]);
				else typeMask <= typeMask & ~(7'(1) << ti1[2:0]);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ledGreen <= 1'b0;
			ledRed <= 1'b0;
			contStop <= 1'b0;
		end else begin
			contStop <= rxIdle && contActive && stopChar;
			if (!ledOverride) begin
				ledGreen <= tagActivity;
				ledRed <= 1'b0;
			end else if (execD && isLed && need == 3'd1) begin
				ledGreen <= args[0] == CH_LG;
				ledRed <= args[0] == CH_LR;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= {DIV_RESET, ID_RESET, 8'h00};
			irqMask <= 3'b000;
			irqStat <= 3'b000;
			irq <= 1'b0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= apbSetup;
			pslverr <= apbSetup && !mapped;
			if (apbSetup && !pwrite) begin
				case (paddr)
					OFF_CTRL: prdata <= ctrl;
					OFF_STAT: prdata <= {16'h0, 1'b0, typeMask, 3'b000, state, ledRed, ledGreen};
					OFF_IRQ:  prdata <= {29'h0, irqStat | irqEvents};
					OFF_MASK: prdata <= {29'h0, irqMask};
					OFF_SET:  prdata <= {24'h0, settings[typeSel]};
					default:  prdata <= 32'h0;
				endcase
			end
			if (apbAcc && pwrite && paddr == OFF_CTRL) ctrl <= pwdata;
			if (apbAcc && pwrite && paddr == OFF_MASK) irqMask <= pwdata[2:0];
			// Set wins over the read clear so no event is lost
			irqStat <= (irqRead ? 3'b000 : irqStat)
				| irqEvents;
			irq <= |(irqStat & irqMask);
		end
	end

	a_led_auto: assert property (@(posedge clk) disable iff (rst)
		!ledOverride && tagActivity |=> ledGreen && !ledRed)
		else $error("Indicator not following activity");
	a_led_cmd: assert property (@(posedge clk) disable iff (rst)
		ledOverride && execD && need == 3'd1 && args[0] == CH_LR |=> ledRed && !ledGreen)
		else $error("Red request not applied");
	a_gain_decode: assert property (@(posedge clk) disable iff (rst)
		execD && need == 3'd2 && args[1] == 8'h80 && ti0[2:0] == typeSel
		|=> curGain == 2'd2 && curSample == 4'd0)
		else $error("Settings byte decoded wrong");
	a_set_reply: assert property (@(posedge clk) disable iff (rst)
		execD && need == 3'd2 && ti0[3] |=> reply[0] == CH_D && reply[1] == $past(args[0]))
		else $error("Settings answer wrong");
	a_slot_hold: assert property (@(posedge clk) disable iff (rst)
		state == ST_SLOT && slotLeft != 8'h00 |=> state == ST_SLOT)
		else $error("Slotted answer left early");
	a_id_frame: assert property (@(posedge clk) disable iff (rst)
		state == ST_SEND && !txValid && idReply && binMode |=> txValid && txFrameV1)
		else $error("Station reply not in version 1 framing");
	a_lock_mode: assert property (@(posedge clk) disable iff (rst)
		state == ST_EXEC && cmd == CH_LK && !lockOk |=> !tagReq && reply[0] == CH_O)
		else $error("Unsupported lock not refused");
	a_type_case: assert property (@(posedge clk) disable iff (rst)
		execO && !isSub && args[0] == CH_LH |=> typeMask == 7'h08)
		else $error("Lower-case type mapped wrong");
	a_noisy_ignore: assert property (@(posedge clk) disable iff (rst)
		rxIdle && contActive && noisy && rxData != CH_DOT |=> !contStop ##1 state == ST_IDLE)
		else $error("Noisy mode reacted to a character");
	a_one_answer: assert property (@(posedge clk) disable iff (rst)
		lastByte |=> state == ST_IDLE && !txValid)
		else $error("Answer did not end cleanly");
	a_settings_quiet: assert property (@(posedge clk) disable iff (rst)
		execD && need == 3'd1 && !isLed && ti0[3] |=> !evBad)
		else $error("Settings type byte raised a refusal");
endmodule : rcp_parser

// *** tb/rcp_host_model.sv ***
// Purpose: Host controller on the serial byte link of the parser.
// Assumes: Same clock as the parser; one command in flight at a time.
// Notes: Idle data line shows the inverse of the last byte, not a stale copy.
`timescale 1ns/1ps
module rcp_host_model (
	input  wire logic       clk,
	output logic            rxValid,
	output logic [7:0]      rxData,
	input  wire logic       txValid,
	input  wire logic [7:0] txData,
	output logic            txReady
);
	initial begin
		rxValid = 1'h0;
		rxData  = 8'h00;
		txReady = 1'h0;
	end
	task automatic send_byte(input logic [7:0] b);
		rxValid <= 1'h1;
		rxData  <= b;
		@(posedge clk);
		rxValid <= 1'h0;
		rxData  <= ~b;
		repeat (2) @(posedge clk);
	endtask : send_byte
	// A stalling host leaves the reply waiting; the parser has to hold it
	// No limit of its own: the bench watchdog ends a hang
	task automatic recv_byte(input int stall, output logic [7:0] b);
		repeat (stall + 1) @(posedge clk);
		txReady <= 1'h1;
		do begin
			@(posedge clk);
		end while (txValid !== 1'h1);
		b = txData;
		txReady <= 1'h0;
	endtask : recv_byte
endmodule : rcp_host_model

// *** tb/rcp_parser_tb.sv ***
// Purpose: Self-checking bench for the serial command interpreter.
// Assumes: Tag engine here answers the cycle after each request.
// Notes: Bit period cut to 2 clocks so station-ID slots stay short.
`timescale 1ns/1ps
module rcp_parser_tb;
	import rcp_pkg::*;
	logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        tagActivity = 1'h0, contActive = 1'h0, tagDone = 1'h0, e, lockSeen;
	logic [7:0]  paddr = 8'h00, tagPresent = 8'h00, rxData, txData;
	logic [31:0] pwdata = 32'h0, prdata, tagArg, argSeen, q;
	logic [2:0]  tagStatus = 3'h0, tagResult = 3'h0;
	logic        pready, pslverr, rxValid, txValid, txReady, txFrameV1, contStop;
	logic        tagReq, tagLock, ledGreen, ledRed, irq;
	logic [6:0]  typeMask;
	logic [1:0]  curGain;
	logic [3:0]  curSample;
	int          numErrors = 0, checksDone = 0, cyc = 0, reqCount = 0, stopCount = 0;
	rcp_parser uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rxValid, .rxData, .txValid, .txData, .txReady, .txFrameV1, .tagActivity,
		.contActive, .contStop, .tagReq, .tagLock, .tagArg, .tagDone, .tagStatus, .tagPresent,
		.ledGreen, .ledRed, .typeMask, .curGain, .curSample, .irq);
	rcp_host_model host (.clk, .rxValid, .rxData, .txValid, .txData, .txReady);
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc     <= cyc + 1;
		tagDone <= 1'h0;
		if (contStop === 1'h1)
			stopCount <= stopCount + 1;
		if (tagReq === 1'h1) begin
			reqCount  <= reqCount + 1;
			argSeen   <= tagArg;
			lockSeen  <= tagLock;
			tagDone   <= 1'h1;
			tagStatus <= tagResult;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			numErrors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'h1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic send(input logic [39:0] bs, input int n);
		for (int i = n - 1; i >= 0; i--)
			host.send_byte(bs[8*i +: 8]);
	endtask : send
	task automatic expect_reply(input logic [23:0] exp, input int n);
		logic [7:0] b;
		for (int i = n - 1; i >= 0; i--) begin
			host.recv_byte(3 * i, b);
			check({24'h0, b}, {24'h0, exp[8*i +: 8]});
		end
		repeat (10) @(posedge clk);
		check({31'h0, txValid}, 32'h0);
	endtask : expect_reply
	task automatic t_reset;
		apb(1'h0, OFF_CTRL, 32'h0);
		check(q, {DIV_RESET, ID_RESET, 8'h00});
		apb(1'h0, OFF_SET, 32'h0);
		check(q, {24'h0, SET_RESET});
		check({25'h0, typeMask}, {25'h0, TYPES_ALL});
		apb(1'h1, 8'h14, 32'hffff_ffff);
		apb(1'h0, 8'h14, 32'h0);
		check({q[31:1], e}, 32'h1);
	endtask : t_reset
	task automatic t_led;
		logic [7:0] par [3] = '{CH_LG, CH_LR, CH_LN};
		logic [7:0] ans [3] = '{CH_G, CH_R, CH_N};
		logic [1:0] led [3] = '{2'h1, 2'h2, 2'h0};
		tagActivity <= 1'h1;
		repeat (3) @(posedge clk);
		check({30'h0, ledRed, ledGreen}, 32'h1);
		apb(1'h1, OFF_CTRL, {DIV_RESET, 16'h0001});
		foreach (par[i]) begin
			send(40'({CH_LD, par[i]}), 2);
			expect_reply(24'({CH_D, ans[i]}), 2);
			check({30'h0, ledRed, ledGreen}, {30'h0, led[i]});
		end
		tagActivity <= 1'h0;
	endtask : t_led
	task automatic t_types;
		logic [23:0] c [5] = '{24'h6f48, 24'h6f2b55, 24'h6f2d48, 24'h6f68, 24'h6f41};
		int          n [5] = '{2, 3, 3, 2, 2};
		logic [6:0]  m [5] = '{7'h10, 7'h11, 7'h01, 7'h08, 7'h7f};
		foreach (c[i]) begin
			send(40'(c[i]), n[i]);
			expect_reply(c[i], n[i]);
			check({25'h0, typeMask}, {25'h0, m[i]});
		end
	endtask : t_types
	task automatic t_settings;
		send(40'({CH_LO, CH_H}), 2);
		expect_reply(24'({CH_LO, CH_H}), 2);
		send(40'({CH_LD, CH_H, 8'h80}), 3);
		expect_reply(24'({CH_D, CH_H}), 2);
		check({26'h0, curGain, curSample}, 32'h20);
		send(40'({CH_LD, CH_H, 8'h7b}), 3);
		expect_reply(24'({CH_D, CH_H}), 2);
		check({26'h0, curGain, curSample}, 32'h1b);
		apb(1'h0, OFF_IRQ, 32'h0);
		check(q & 32'h2, 32'h0);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		check({26'h0, curGain, curSample}, 32'h24);
		check({25'h0, typeMask}, {25'h0, TYPES_ALL});
	endtask : t_settings
	task automatic t_tag;
		logic [2:0]  st [9] = '{TS_OK, TS_CRC, TS_FAIL, TS_NOTAG, TS_RANGE, TS_MODE,
			TS_OK, TS_KEY, TS_NOTAG};
		logic [15:0] an [9] = '{16'h6b05, 16'h43, 16'h46, 16'h4e, 16'h52, 16'h4f,
			16'h4c, 16'h58, 16'h4e};
		tagPresent <= CH_Q;
		foreach (st[i]) begin
			tagResult = st[i];
			if (i < 6) begin
				send(40'({CH_LK, 8'h05}), 2);
				expect_reply(24'(an[i]), (i == 0) ? 2 : 1);
				check({lockSeen, 23'h0, argSeen[31:24]}, {1'h1, 23'h0, 8'h05});
			end else begin
				send({CH_LL, 32'h0123_4567}, 5);
				expect_reply(24'(an[i]), 1);
				check({argSeen[30:0], lockSeen}, {31'h0123_4567, 1'h0});
			end
		end
		tagPresent <= CH_U;
		send(40'({CH_LK, 8'h05}), 2);
		expect_reply(24'(CH_O), 1);
		check(32'(reqCount), 32'h9);
	endtask : t_tag
	task automatic t_slot;
		int t0;
		logic [7:0] b;
		for (int bin = 1; bin >= 0; bin--) begin
			apb(1'h1, OFF_CTRL, 32'h0002_0300 | 32'(bin << CTL_BIN));
			send(40'(CH_LG), 1);
			t0 = cyc;
			host.recv_byte(0, b);
			check({24'h0, b}, 32'h3);
			check({31'h0, txFrameV1}, 32'(bin));
			if (bin == 1)
				check(32'((cyc - t0) >= 3 * SLOT_CHARS * SLOT_BITS * 2 - 4), 32'h1);
			check(32'((cyc - t0) < (bin ? 660 : 20)), 32'h1);
		end
	endtask : t_slot
	task automatic t_stop_irq;
		apb(1'h1, OFF_MASK, 32'h4);
		apb(1'h1, OFF_CTRL, {DIV_RESET, 16'h0004});
		contActive <= 1'h1;
		send(40'(8'h78), 1);
		repeat (20) @(posedge clk);
		check({31'h0, txValid}, 32'h0);
		send(40'(CH_DOT), 1);
		expect_reply(24'(CH_S), 1);
		contActive <= 1'h0;
		check({31'h0, irq} + 32'(stopCount), 32'h2);
		apb(1'h0, OFF_IRQ, 32'h0);
		check(q & 32'h4, 32'h4);
		apb(1'h0, OFF_IRQ, 32'h0);
		check((q & 32'h4) | {31'h0, irq}, 32'h0);
		send(40'(8'h7a), 1);
		expect_reply(24'(CH_QM), 1);
		apb(1'h0, OFF_IRQ, 32'h0);
		check(q & 32'h2, 32'h2);
	endtask : t_stop_irq
	task automatic reportAndStop;
		$display("Checks %0d, errors %0d", checksDone, numErrors);
		if (numErrors == 0 && checksDone > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : reportAndStop
	initial begin
		repeat (60000) @(posedge clk);
		numErrors++;
		reportAndStop;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		t_reset;
		t_led;
		t_types;
		t_settings;
		t_tag;
		t_slot;
		t_stop_irq;
		reportAndStop;
	end
endmodule : rcp_parser_tb
